/* hdl/ars_defs.svh */
// Purpose: timing constants of the reclose sequencer
// Assumes: 200 MHz system clock, timers count in milliseconds
// Notes: every timing figure lives here as a macro
`ifndef ARS_DEFS_SVH
`define ARS_DEFS_SVH

`define ARS_CLK_PERIOD_NS 5
`define ARS_MS_NS 1000000
`define ARS_CYC_PER_MS (`ARS_MS_NS / `ARS_CLK_PERIOD_NS)
`define ARS_SUPV_EXTRA_MS 17'h0_0096
`define ARS_TMR_W 17
`define ARS_CFG_W 16
`define ARS_NUM_ELEM 8
`define ARS_NUM_SHOT 4
`define ARS_LAST_SHOT 2'h3
`define ARS_CNT_W 16

`endif

/* hdl/ars_pkg.sv */
// Purpose: types of the reclose sequencer
// Assumes: constants come from ars_defs.svh
// Notes: none
`include "ars_defs.svh"

package ars_pkg;
	typedef enum logic [2:0] {
		ARS_IDLE,
		ARS_WAIT_OPEN,
		ARS_DEAD,
		ARS_CLOSING,
		ARS_RECLAIM,
		ARS_LOCKOUT
	} ars_state_t;

	typedef logic [`ARS_NUM_SHOT-1:0] ars_shot_bits_t;
	typedef logic [`ARS_TMR_W-1:0] ars_tmr_val_t;
endpackage : ars_pkg

/* hdl/ars_tmr_if.sv */
// Purpose: carries one millisecond timer between sequencer and timer
// Assumes: one clock domain
// Notes: load wins over stop
`timescale 1ns/1ps

interface ars_tmr_if;
	import ars_pkg::*;
	logic load;
	logic stop;
	ars_tmr_val_t value;
	logic tick;
	logic busy;
	logic expired;
	modport owner (output load, stop, value, tick, input busy, expired);
	modport timer (input load, stop, value, tick, output busy, expired);
endinterface : ars_tmr_if

/* hdl/ars_ms_timer.sv */
// Purpose: down counter in milliseconds with a one-cycle expiry pulse
// Assumes: tick is a one-cycle pulse per millisecond
// Notes: a value of zero expires at the next tick
`timescale 1ns/1ps

module ars_ms_timer
	import ars_pkg::*;
(
	input wire logic clk_sys_i, // system clock
	input wire logic srst_i, // sync reset, high
	ars_tmr_if.timer t // timer control
);
	ars_tmr_val_t cnt;

	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			cnt <= '0;
			t.busy <= 1'b0;
			t.expired <= 1'b0;
		end else begin
			t.expired <= 1'b0;
			if (t.load) begin
				cnt <= t.value;
				t.busy <= 1'b1;
			end else if (t.stop) begin
				t.busy <= 1'b0;
			end else if (t.busy && t.tick) begin
				if (cnt <= ars_tmr_val_t'(1)) begin
					t.busy <= 1'b0;
					t.expired <= 1'b1;
				end else begin
					cnt <= cnt - ars_tmr_val_t'(1);
				end
			end
		end
	end
endmodule : ars_ms_timer

/* hdl/ars_sequencer.sv */
// Purpose: automatic reclose sequencer with trip inhibit and fast trip
// Assumes: element starts and trips come from logic on clk_sys_i
// Notes: breaker contact is a pin and is synchronised here
// Contract
// - five status outputs: in progress, final trip, lockout, blocked, ok
// - in progress from sequence start until reclaim end or lockout
// - final trip when shots exhausted and fault persists, latched
// - final trip cleared by late manual close or reset command
// - success flag cleared when a new sequence starts
// - one to four shots, enabled per initiating element
// - separate dead interval per shot, current shot's one used
// - dead interval starts on breaker open or protection reset
// - dead expiry gives close order, supervision is pulse plus 150 ms
// - breaker not closed at supervision end: lockout and alarm
// - reclaim starts on breaker close, expiry returns to idle
// - trip during reclaim advances a shot or locks out
// - total reclosures counted and readable
// - per-shot inhibit bit for eight elements, 1 suppresses trip
// - rightmost inhibit bit belongs to the first cycle
// - inhibition removed only after the stage resets
// - shot advance drops inhibitions, reapplies next shot's ones
// - separate fast-trip selection for phase and earth groups
// - fast shot trips after the fast delay, rightmost bit first
// - phase selection covers three phase stages, earth three earth
// - fast delay is definite time regardless of curve
// - fast trip applies no reset delay
// - lockout left by late manual close or reset, alarm held till then
// - manual close blocks initiation for the inhibit interval
`timescale 1ns/1ps
`include "ars_defs.svh"

module ars_sequencer
	import ars_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = `ARS_CYC_PER_MS
) (
	input wire logic clk_sys_i, // system clock
	input wire logic srst_i, // sync reset, high
	input wire logic enable_i, // function enabled
	input wire logic ext_block_i, // external block level
	input wire logic [7:0] elem_start_i, // stage picked up
	input wire logic [7:0] elem_trip_i, // stage own delayed trip
	input wire logic breaker_closed_contact_i, // breaker aux pin
	input wire logic manual_close_i, // manual close pulse
	input wire logic reset_latched_i, // reset latched signalling
	input wire logic dead_start_on_cb_i, // 1 breaker open, 0 reset
	input wire logic [7:0][3:0] close_shot_cfg_i, // shot enables
	input wire logic [7:0][3:0] inhibit_cfg_i, // trip inhibits
	input wire logic [4:0] fast_phase_cfg_i, // phase fast trips
	input wire logic [4:0] fast_earth_cfg_i, // earth fast trips
	input wire logic [15:0] dead_interval_shot1_i, // ms
	input wire logic [15:0] dead_interval_shot2_i, // ms
	input wire logic [15:0] dead_interval_shot3_i, // ms
	input wire logic [15:0] dead_interval_shot4_i, // ms
	input wire logic [15:0] reclaim_interval_i, // ms
	input wire logic [15:0] close_pulse_length_i, // ms
	input wire logic [15:0] manual_close_inhibit_i, // ms
	input wire logic [15:0] fast_trip_delay_i, // ms
	output logic [7:0] trip_o, // trip per element
	output logic breaker_close_order_o, // close order
	output logic in_progress_o, // cycle in progress
	output logic final_trip_o, // final trip latched
	output logic lockout_o, // internal block
	output logic ext_blocked_o, // external block
	output logic success_o, // reclose successful
	output logic close_supervision_alarm_o, // close failed
	output logic [15:0] reclose_count_o // total reclosures
);
	////////////////////////////////////////////////////////////////////
	// helpers

	function automatic ars_tmr_val_t dead_for(input logic [1:0] s,
		input logic [15:0] d1, input logic [15:0] d2,
		input logic [15:0] d3, input logic [15:0] d4);
		case (s)
			2'h0: dead_for = {1'b0, d1};
			2'h1: dead_for = {1'b0, d2};
			2'h2: dead_for = {1'b0, d3};
			default: dead_for = {1'b0, d4};
		endcase
	endfunction : dead_for

	// shot bit of every element, rightmost bit is the first cycle
	function automatic logic [7:0] shot_col(input logic [7:0][3:0] cfg,
		input logic [1:0] s);
		logic [7:0] r;
		r = '0;
		for (int e = 0; e < 8; e++) begin
			r[e] = cfg[e][s];
		end
		shot_col = r;
	endfunction : shot_col

	////////////////////////////////////////////////////////////////////
	// breaker contact synchroniser

	logic cb_s1;
	logic cb_s2;
	logic cb_s3;
	logic cb_closed;

	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			cb_s1 <= 1'b0;
			cb_s2 <= 1'b0;
			cb_s3 <= 1'b0;
			cb_closed <= 1'b0;
		end else begin
			cb_s1 <= breaker_closed_contact_i;
			cb_s2 <= cb_s1;
			cb_s3 <= cb_s2;
			if (cb_s2 == cb_s3) begin
				cb_closed <= cb_s3;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// millisecond tick and timers

	logic [17:0] div;
	logic tick;

	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			div <= '0;
			tick <= 1'b0;
		end else if (div == 18'(TICK_CYCLES - 1)) begin
			div <= '0;
			tick <= 1'b1;
		end else begin
			div <= div + 18'h0_0001;
			tick <= 1'b0;
		end
	end

	ars_tmr_if t_seq ();
	ars_tmr_if t_man ();
	ars_tmr_if t_fph ();
	ars_tmr_if t_fe ();

	ars_ms_timer u_seq (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .t(t_seq));
	ars_ms_timer u_man (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .t(t_man));
	ars_ms_timer u_fph (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .t(t_fph));
	ars_ms_timer u_fe (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .t(t_fe));

	assign t_seq.tick = tick;
	assign t_man.tick = tick;
	assign t_fph.tick = tick;
	assign t_fe.tick = tick;

	////////////////////////////////////////////////////////////////////
	// sequencer

	ars_state_t state;
	logic [1:0] shot;
	logic [2:0] closes;
	logic [7:0] inh_act;
	logic [7:0] init_ok;
	logic [7:0] next_ok;
	logic ready;
	logic can_next;

	assign init_ok = shot_col(close_shot_cfg_i, 2'h0);
	assign next_ok = shot_col(close_shot_cfg_i, shot + 2'h1);
	assign can_next = (shot != `ARS_LAST_SHOT) && |(trip_o & next_ok);
	assign ready = enable_i && !ext_block_i && !t_man.busy;

	// manual close inhibit timer
	assign t_man.load = manual_close_i;
	assign t_man.stop = 1'b0;
	assign t_man.value = {1'b0, manual_close_inhibit_i};

	always_comb begin
		t_seq.load = 1'b0;
		t_seq.stop = 1'b0;
		t_seq.value = '0;
		case (state)
			ARS_WAIT_OPEN: begin
				t_seq.load = dead_start_on_cb_i ? !cb_closed : ~|elem_start_i;
				t_seq.value = dead_for(shot, dead_interval_shot1_i,
					dead_interval_shot2_i, dead_interval_shot3_i,
					dead_interval_shot4_i);
			end
			ARS_DEAD: begin
				t_seq.load = t_seq.expired;
				t_seq.value = {1'b0, close_pulse_length_i} + `ARS_SUPV_EXTRA_MS;
			end
			ARS_CLOSING: begin
				t_seq.load = cb_closed;
				t_seq.value = {1'b0, reclaim_interval_i};
			end
			ARS_RECLAIM: t_seq.stop = |trip_o;
			default: t_seq.stop = 1'b1;
		endcase
	end

	// state, shot index and reclose counts
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			state <= ARS_IDLE;
			shot <= 2'h0;
			closes <= 3'h0;
		end else begin
			case (state)
				ARS_IDLE: begin
					closes <= 3'h0;
					if (ready && |(trip_o & init_ok)) begin
						shot <= 2'h0;
						state <= ARS_WAIT_OPEN;
					end
				end
				ARS_WAIT_OPEN: if (t_seq.load) state <= ARS_DEAD;
				ARS_DEAD: if (t_seq.expired) state <= ARS_CLOSING;
				ARS_CLOSING: begin
					if (cb_closed) begin
						closes <= closes + 3'h1;
						state <= ARS_RECLAIM;
					end else if (t_seq.expired) begin
						state <= ARS_LOCKOUT;
					end
				end
				ARS_RECLAIM: begin
					if (|trip_o) begin
						if (can_next) begin
							shot <= shot + 2'h1;
							state <= ARS_WAIT_OPEN;
						end else begin
							state <= ARS_LOCKOUT;
						end
					end else if (t_seq.expired) begin
						state <= ARS_IDLE;
					end
				end
				ARS_LOCKOUT: begin
					if (reset_latched_i || (t_man.expired && cb_closed)) begin
						state <= ARS_IDLE;
					end
				end
				default: state <= ARS_IDLE;
			endcase
		end
	end

	// trip inhibitions
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			inh_act <= '0;
		end else if (state == ARS_CLOSING && cb_closed) begin
			inh_act <= shot_col(inhibit_cfg_i, shot);
		end else if (state == ARS_RECLAIM && can_next && |trip_o) begin
			inh_act <= '0;
		end else if (state == ARS_LOCKOUT || state == ARS_IDLE) begin
			inh_act <= inh_act & elem_start_i;
		end
	end

	////////////////////////////////////////////////////////////////////
	// fast trips and trip outputs

	logic ph_any;
	logic e_any;
	logic ph_any_d;
	logic e_any_d;
	logic fph_sel;
	logic fe_sel;
	logic fph_fire;
	logic fe_fire;
	logic [7:0] fast_mask;
	logic [7:0] next_trip;

	assign ph_any = |elem_start_i[2:0];
	assign e_any = |elem_start_i[5:3];
	assign fph_sel = fast_phase_cfg_i[closes];
	assign fe_sel = fast_earth_cfg_i[closes];
	assign t_fph.load = ph_any && !ph_any_d && fph_sel;
	assign t_fph.value = {1'b0, fast_trip_delay_i};
	assign t_fph.stop = !ph_any;
	assign t_fe.load = e_any && !e_any_d && fe_sel;
	assign t_fe.value = {1'b0, fast_trip_delay_i};
	assign t_fe.stop = !e_any;
	assign fast_mask = {2'b00, {3{fe_sel}}, {3{fph_sel}}};

	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			ph_any_d <= 1'b0;
			e_any_d <= 1'b0;
			fph_fire <= 1'b0;
			fe_fire <= 1'b0;
		end else begin
			ph_any_d <= ph_any;
			e_any_d <= e_any;
			fph_fire <= ph_any && (fph_fire || t_fph.expired);
			fe_fire <= e_any && (fe_fire || t_fe.expired);
		end
	end

	always_comb begin
		next_trip = elem_trip_i & ~fast_mask;
		next_trip[2:0] = next_trip[2:0] | ({3{fph_fire}} & elem_start_i[2:0]);
		next_trip[5:3] = next_trip[5:3] | ({3{fe_fire}} & elem_start_i[5:3]);
		next_trip = next_trip & ~inh_act;
	end

	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			trip_o <= '0;
		end else begin
			trip_o <= next_trip;
		end
	end

	////////////////////////////////////////////////////////////////////
	// status outputs

	logic to_lock;
	logic fin_now;

	assign to_lock = (state == ARS_CLOSING && !cb_closed && t_seq.expired)
		|| (state == ARS_RECLAIM && |trip_o && !can_next);
	assign fin_now = state == ARS_RECLAIM && |trip_o && !can_next;

	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			breaker_close_order_o <= 1'b0;
			in_progress_o <= 1'b0;
			final_trip_o <= 1'b0;
			lockout_o <= 1'b0;
			ext_blocked_o <= 1'b0;
			success_o <= 1'b0;
			close_supervision_alarm_o <= 1'b0;
			reclose_count_o <= '0;
		end else begin
			ext_blocked_o <= ext_block_i;
			breaker_close_order_o <= (state == ARS_DEAD && t_seq.expired)
				|| (state == ARS_CLOSING && !cb_closed && !t_seq.expired);
			if (state == ARS_IDLE && ready && |(trip_o & init_ok)) begin
				in_progress_o <= 1'b1;
			end else if (to_lock || (state == ARS_RECLAIM && !(|trip_o)
				&& t_seq.expired)) begin
				in_progress_o <= 1'b0;
			end
			if (state == ARS_IDLE && ready && |(trip_o & init_ok)) begin
				success_o <= 1'b0;
			end else if (state == ARS_RECLAIM && !(|trip_o) && t_seq.expired) begin
				success_o <= 1'b1;
			end
			if (fin_now) begin
				final_trip_o <= 1'b1;
			end else if (reset_latched_i || (t_man.expired && cb_closed)) begin
				final_trip_o <= 1'b0;
			end
			if (to_lock) begin
				lockout_o <= 1'b1;
				close_supervision_alarm_o <= state == ARS_CLOSING;
			end else if (state == ARS_LOCKOUT && (reset_latched_i
				|| (t_man.expired && cb_closed))) begin
				lockout_o <= 1'b0;
				close_supervision_alarm_o <= 1'b0;
			end
			if (state == ARS_CLOSING && cb_closed) begin
				reclose_count_o <= reclose_count_o + 16'h0001;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb_chk @(posedge clk_sys_i); endclocking
	default disable iff (srst_i);

	a_prog_on_start: assert property (
		state == ARS_IDLE && ready && |(trip_o & init_ok) |=> in_progress_o)
		else $error("in progress not set at start");
	a_succ_clear: assert property (
		$rose(in_progress_o) |-> !success_o)
		else $error("success left set at start");
	a_final_latch: assert property (
		final_trip_o && !reset_latched_i && !t_man.expired |=> final_trip_o)
		else $error("final trip dropped without reset");
	a_lock_prog: assert property (
		lockout_o |-> !in_progress_o)
		else $error("in progress during lockout");
	a_close_order: assert property (
		state == ARS_DEAD && t_seq.expired |=> breaker_close_order_o
		&& state == ARS_CLOSING)
		else $error("no close order at dead end");
	a_supv_alarm: assert property (
		state == ARS_CLOSING && !cb_closed && t_seq.expired
		|=> lockout_o && close_supervision_alarm_o)
		else $error("missing lockout on failed close");
	a_count_step: assert property (
		state == ARS_CLOSING && cb_closed
		|=> reclose_count_o == $past(reclose_count_o) + 16'h0001)
		else $error("reclose count not advanced");
	a_inhib_mask: assert property (
		inh_act[0] |=> !trip_o[0])
		else $error("inhibited trip passed");
	a_man_block: assert property (
		t_man.busy && state == ARS_IDLE |=> state == ARS_IDLE)
		else $error("sequence started during manual inhibit");
	a_lock_hold: assert property (
		lockout_o && !reset_latched_i && !t_man.expired |=> lockout_o)
		else $error("lockout dropped without reset");

	c_success: cover property (state == ARS_RECLAIM && t_seq.expired);
	c_advance: cover property (state == ARS_RECLAIM && |trip_o && can_next);
	c_final: cover property ($rose(final_trip_o));
	c_fast: cover property ($rose(fph_fire));
endmodule : ars_sequencer

/* verif/ars_breaker_model.sv */
// Purpose: breaker with an auxiliary contact for the reclose sequencer
// Assumes: trips and close orders are levels on clk_sys_i
// Notes: refuse_close_i makes the mechanism ignore close orders
`timescale 1ns/1ps

module ars_breaker_model (
	input wire logic clk_sys_i, // system clock
	input wire logic [7:0] trip_i, // trip per element
	input wire logic close_order_i, // automatic close order
	input wire logic manual_close_i, // manual close pulse
	input wire logic refuse_close_i, // stuck closing mechanism
	output logic closed_o // auxiliary contact, high closed
);
	int open_cnt = 0;
	int close_cnt = 0;
	initial closed_o = 1'b1;
	// mechanism travel takes a few cycles, trip wins
	always @(posedge clk_sys_i) begin
		if (|trip_i && closed_o)
			open_cnt <= open_cnt + 1;
		else
			open_cnt <= 0;
		if (close_order_i && !refuse_close_i && !closed_o)
			close_cnt <= close_cnt + 1;
		else
			close_cnt <= 0;
		if (open_cnt == 3)
			closed_o <= 1'b0;
		else if (close_cnt == 5 || manual_close_i)
			closed_o <= 1'b1;
	end
endmodule : ars_breaker_model

/* verif/testbench.sv */
// Purpose: scenario bench of the reclose sequencer
// Assumes: millisecond tick shortened to 4 cycles
// Notes: breaker model answers trips and close orders
`timescale 1ns/1ps

module testbench;
	localparam int IP = 0;
	localparam int FT = 1;
	localparam int LO = 2;
	localparam int EB = 3;
	localparam int OK = 4;
	localparam int AL = 5;
	localparam int CO = 6;
	localparam int TR = 7;
	localparam int CT = 8;
	logic clk_sys_i, srst_i, enable_i, ext_block_i, refuse;
	logic [7:0] elem_start_i, elem_trip_i, trip_o;
	logic breaker_closed_contact_i, manual_close_i, reset_latched_i;
	logic dead_start_on_cb_i;
	logic [7:0][3:0] close_shot_cfg_i, inhibit_cfg_i;
	logic [4:0] fast_phase_cfg_i, fast_earth_cfg_i;
	logic [15:0] dead_interval_shot1_i, dead_interval_shot2_i;
	logic [15:0] dead_interval_shot3_i, dead_interval_shot4_i;
	logic [15:0] reclaim_interval_i, close_pulse_length_i;
	logic [15:0] manual_close_inhibit_i, fast_trip_delay_i;
	logic breaker_close_order_o, in_progress_o, final_trip_o, lockout_o;
	logic ext_blocked_o, success_o, close_supervision_alarm_o;
	logic [15:0] reclose_count_o;
	logic [8:0] st;
	int error_cnt = 0;
	int tests_run = 0;
	int n;
	assign st = {breaker_closed_contact_i, trip_o[0], breaker_close_order_o,
		close_supervision_alarm_o, success_o, ext_blocked_o, lockout_o,
		final_trip_o, in_progress_o};

	ars_sequencer #(.TICK_CYCLES(4)) uut (.clk_sys_i, .srst_i, .enable_i,
		.ext_block_i, .elem_start_i, .elem_trip_i, .breaker_closed_contact_i,
		.manual_close_i, .reset_latched_i, .dead_start_on_cb_i,
		.close_shot_cfg_i, .inhibit_cfg_i, .fast_phase_cfg_i,
		.fast_earth_cfg_i, .dead_interval_shot1_i, .dead_interval_shot2_i,
		.dead_interval_shot3_i, .dead_interval_shot4_i, .reclaim_interval_i,
		.close_pulse_length_i, .manual_close_inhibit_i, .fast_trip_delay_i,
		.trip_o, .breaker_close_order_o, .in_progress_o, .final_trip_o,
		.lockout_o, .ext_blocked_o, .success_o, .close_supervision_alarm_o,
		.reclose_count_o);
	ars_breaker_model brk (.clk_sys_i, .trip_i(trip_o),
		.close_order_i(breaker_close_order_o), .manual_close_i,
		.refuse_close_i(refuse), .closed_o(breaker_closed_contact_i));

	////////////////////////////////////////
	task automatic chk(input string nm, input logic [15:0] e,
		input logic [15:0] g);
		tests_run++;
		if (g !== e) begin
			$display("Error: %s expected %h seen %h", nm, e, g);
			error_cnt++;
		end
	endtask : chk

	task automatic wait_bit(input int k, input logic v, input int lim,
		output int c);
		c = 0;
		while (st[k] !== v && c < lim) begin
			@(posedge clk_sys_i);
			#1;
			c++;
		end
		if (st[k] !== v) begin
			$display("Error: status bit %0d expected %b seen %b", k, v, st[k]);
			error_cnt++;
		end
	endtask : wait_bit

	task automatic trip_open(input int e);
		@(posedge clk_sys_i);
		elem_start_i[e] <= 1'b1;
		elem_trip_i[e] <= 1'b1;
		wait_bit(CT, 1'b0, 20, n);
		@(posedge clk_sys_i);
		elem_start_i <= 8'h00;
		elem_trip_i <= 8'h00;
	endtask : trip_open

	task automatic await_close;
		wait_bit(CO, 1'b1, 100, n);
		wait_bit(CO, 1'b0, 50, n);
	endtask : await_close

	task automatic pulse_manual;
		@(posedge clk_sys_i);
		manual_close_i <= 1'b1;
		@(posedge clk_sys_i);
		manual_close_i <= 1'b0;
	endtask : pulse_manual

	task automatic reclose;
		pulse_manual();
		wait_bit(CT, 1'b1, 10, n);
		repeat (32) @(posedge clk_sys_i);
		#1;
	endtask : reclose

	task automatic no_start(input int e);
		@(posedge clk_sys_i);
		elem_trip_i[e] <= 1'b1;
		repeat (8) @(posedge clk_sys_i);
		#1;
		chk("start refused", 16'h0000, {15'h0000, in_progress_o});
		@(posedge clk_sys_i);
		elem_trip_i <= 8'h00;
		reclose();
	endtask : no_start

	////////////////////////////////////////
	task automatic s_success;
		trip_open(0);
		chk("in progress", 16'h0001, {15'h0000, in_progress_o});
		wait_bit(CO, 1'b1, 100, n);
		chk("shot one dead", 16'h0001, {15'h0000, n >= 4 && n <= 16});
		wait_bit(CO, 1'b0, 50, n);
		chk("count", 16'h0001, reclose_count_o);
		wait_bit(IP, 1'b0, 60, n);
		chk("reclaim span", 16'h0001, {15'h0000, n >= 16 && n <= 30});
		chk("success", 16'h0001, {15'h0000, success_o});
	endtask : s_success

	task automatic s_exhaust;
		trip_open(0);
		chk("success cleared", 16'h0000, {15'h0000, success_o});
		await_close();
		trip_open(0); // second shot
		wait_bit(CO, 1'b1, 100, n);
		chk("shot two dead", 16'h0001, {15'h0000, n >= 20 && n <= 32});
		wait_bit(CO, 1'b0, 50, n);
		chk("count", 16'h0003, reclose_count_o);
		trip_open(0);
		wait_bit(FT, 1'b1, 10, n); // shots used
		chk("lockout", 16'h0001, {15'h0000, lockout_o});
		chk("in progress", 16'h0000, {15'h0000, in_progress_o});
		repeat (10) @(posedge clk_sys_i);
		chk("final held", 16'h0001, {15'h0000, final_trip_o});
		reset_latched_i <= 1'b1;
		@(posedge clk_sys_i);
		reset_latched_i <= 1'b0;
		wait_bit(FT, 1'b0, 6, n); // reset command
		chk("lockout", 16'h0000, {15'h0000, lockout_o});
	endtask : s_exhaust

	task automatic s_refuse;
		pulse_manual();
		wait_bit(CT, 1'b1, 10, n);
		no_start(0); // manual inhibit
		@(posedge clk_sys_i);
		enable_i <= 1'b0;
		no_start(0); // disabled
		@(posedge clk_sys_i);
		enable_i <= 1'b1;
		ext_block_i <= 1'b1;
		wait_bit(EB, 1'b1, 4, n); // external block
		no_start(0); // blocked
		@(posedge clk_sys_i);
		ext_block_i <= 1'b0;
		wait_bit(EB, 1'b0, 4, n); // block released
		no_start(1); // shot bit clear
	endtask : s_refuse

	task automatic s_fail;
		refuse <= 1'b1;
		trip_open(0);
		wait_bit(CO, 1'b1, 100, n);
		wait_bit(LO, 1'b1, 700, n);
		chk("supervision", 16'h0001, {15'h0000, n >= 612 && n <= 630});
		chk("alarm", 16'h0001, {15'h0000, close_supervision_alarm_o});
		chk("final trip", 16'h0000, {15'h0000, final_trip_o});
		@(posedge clk_sys_i);
		refuse <= 1'b0;
		pulse_manual();
		wait_bit(LO, 1'b0, 60, n);
		chk("unlock delay", 16'h0001, {15'h0000, n >= 16 && n <= 40});
		chk("alarm", 16'h0000, {15'h0000, close_supervision_alarm_o});
		repeat (8) @(posedge clk_sys_i);
	endtask : s_fail

	task automatic s_fast;
		@(posedge clk_sys_i);
		fast_phase_cfg_i <= 5'h01;
		dead_start_on_cb_i <= 1'b0;
		elem_start_i[0] <= 1'b1;
		wait_bit(TR, 1'b1, 20, n);
		chk("fast delay", 16'h0001, {15'h0000, n <= 8});
		wait_bit(CT, 1'b0, 10, n);
		@(posedge clk_sys_i);
		elem_start_i <= 8'h00;
		await_close(); // start reset
		wait_bit(IP, 1'b0, 60, n);
		chk("count", 16'h0006, reclose_count_o);
	endtask : s_fast

	task automatic s_inhibit;
		@(posedge clk_sys_i);
		inhibit_cfg_i <= 32'h0000_0001;
		trip_open(0);
		await_close();
		@(posedge clk_sys_i);
		elem_start_i[0] <= 1'b1;
		elem_trip_i[0] <= 1'b1;
		wait_bit(IP, 1'b0, 60, n);
		chk("inhibited trip", 16'h0000, {15'h0000, trip_o[0]});
		chk("success", 16'h0001, {15'h0000, success_o});
		repeat (8) @(posedge clk_sys_i);
		#1;
		chk("inhibit held", 16'h0000, {15'h0000, trip_o[0]});
		@(posedge clk_sys_i);
		elem_start_i <= 8'h00;
		elem_trip_i <= 8'h00;
		trip_open(0);
		chk("inhibit freed", 16'h0001, {15'h0000, in_progress_o});
		await_close();
		wait_bit(IP, 1'b0, 60, n);
		@(posedge clk_sys_i);
		inhibit_cfg_i <= 32'h0000_0000;
	endtask : s_inhibit

	////////////////////////////////////////
	task automatic results;
		$display("Errors %0d in %0d checks", error_cnt, tests_run);
		if (error_cnt == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : results

	initial begin
		clk_sys_i = 1'b0;
		forever #2.5 clk_sys_i = ~clk_sys_i;
	end

	initial begin
		repeat (20000) @(posedge clk_sys_i);
		error_cnt++;
		results();
	end

	initial begin
		srst_i = 1'b1;
		enable_i = 1'b1;
		ext_block_i = 1'b0;
		refuse = 1'b0;
		elem_start_i = 8'h00;
		elem_trip_i = 8'h00;
		manual_close_i = 1'b0;
		reset_latched_i = 1'b0;
		dead_start_on_cb_i = 1'b1;
		close_shot_cfg_i = 32'h0000_0003;
		inhibit_cfg_i = 32'h0000_0000;
		fast_phase_cfg_i = 5'h00;
		fast_earth_cfg_i = 5'h00;
		dead_interval_shot1_i = 16'h0002;
		dead_interval_shot2_i = 16'h0006;
		dead_interval_shot3_i = 16'h0004;
		dead_interval_shot4_i = 16'h0005;
		reclaim_interval_i = 16'h0005;
		close_pulse_length_i = 16'h0005;
		manual_close_inhibit_i = 16'h0006;
		fast_trip_delay_i = 16'h0001;
		repeat (4) @(posedge clk_sys_i);
		srst_i <= 1'b0;
		@(posedge clk_sys_i);
		#1;
		chk("outputs after reset", 16'h0000, {8'h00, st[7:0]});
		chk("count after reset", 16'h0000, reclose_count_o);
		s_success();
		s_exhaust();
		s_refuse();
		s_fail();
		s_inhibit();
		s_fast();
		results();
	end
endmodule : testbench
